// file: pkg/ibe_defines.svh
// Offsets, field positions, reset values and rate constants of the serial byte engine.
// Assumes a 32-bit register port with byte addresses of IBE_ADDR_W bits.
`ifndef IBE_DEFINES_SVH
`define IBE_DEFINES_SVH

// Register byte addresses
`define IBE_ADDR_W   12
`define IBE_CTRL_OFS 12'h110
`define IBE_STS_OFS  12'h180
`define IBE_MSK_OFS  12'h184

// Control word fields
`define IBE_BYTES_LSB 8
`define IBE_DIR_BIT   24
`define IBE_DIV_LSB   4
`define IBE_SYNC_BIT  3
`define IBE_W3B_BIT   2
`define IBE_SCL_BIT   1
`define IBE_SDA_BIT   0

// Status fields
`define IBE_EV_DONE 0
`define IBE_EV_NACK 1
`define IBE_ST_DONE 8
`define IBE_ST_BUSY 9

// Reset values
`define IBE_BYTES_RST 24'h000000
`define IBE_DIV_RST   4'h0
`define IBE_MSK_RST   2'h0

// Bit rate: clock / PRESCALE / divider, each bit split in QUARTERS phases
`define IBE_PRESCALE 16
`define IBE_QUARTERS 4

`endif

// file: pkg/ibe_pkg.sv
// Types shared by the serial byte engine and its rate divider.
// Assumes ibe_defines.svh sits on the include path.
package ibe_pkg;
  // Engine sequence states
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_BIT, ST_ACK, ST_STOP} ibe_state_t;

  // One value for each of the two serial lines
  typedef struct packed {
    logic scl;
    logic sda;
  } ibe_line_t;
endpackage

// file: rtl/ibe_rate_div.sv
// Quarter-bit tick generator for the serial byte engine.
// Assumes div is stable while run is high; div of zero gives no tick.
`timescale 1ns/1ps
`include "ibe_defines.svh"
module ibe_rate_div import ibe_pkg::*; #(
  parameter int DIV_W = 4
) (
  input  wire logic             clk_sys, // System clock
  input  wire logic             arst_n,  // Asynchronous reset, active low
  input  wire logic             run,     // Count while high
  input  wire logic [DIV_W-1:0] div,     // Programmable divider
  output logic                  tick     // One-cycle quarter-bit pulse
);
  localparam int CW = DIV_W + 3;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic          tick_reg, tick_next;
  logic [CW-1:0] lim;

  // Quarter period is PRESCALE/QUARTERS times the divider
  assign lim = CW'(`IBE_PRESCALE / `IBE_QUARTERS) * CW'(div) - CW'(1);

  // Next count and tick
  always_comb begin
    cnt_next  = cnt_reg + CW'(1);
    tick_next = 1'b0;
    if (!run || div == '0) begin
      cnt_next = '0;
    end else if (cnt_reg >= lim) begin
      cnt_next  = '0;
      tick_next = 1'b1;
    end
  end

  // Counter registers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;
endmodule

// file: rtl/ibe_byte_engine.sv
// Two-wire serial master with one control word, a status and a mask register.
// Assumes a register master that keeps the strobe protocol and open-drain pads outside.
`timescale 1ns/1ps
`include "ibe_defines.svh"
module ibe_byte_engine import ibe_pkg::*; (
  input  wire logic                   clk_sys, // System clock, 250 MHz
  input  wire logic                   arst_n,  // Asynchronous reset, active low
  input  wire logic [`IBE_ADDR_W-1:0] addr,    // Register byte address
  input  wire logic [31:0]            wdata,   // Write data
  input  wire logic                   wr,      // Write strobe
  input  wire logic                   rd,      // Read strobe
  output logic      [31:0]            rdata,   // Read data, cycle after rd
  input  ibe_line_t                   line_i,  // Line levels from the pads
  output ibe_line_t                   line_o,  // Line output values, always low
  output ibe_line_t                   line_oe, // High while pulling a line low
  output logic                        irq      // Level interrupt
);
  ibe_state_t  state_reg, st_next;
  logic [1:0]  q_reg, q_next;
  logic [2:0]  bit_reg, bit_next;
  logic [1:0]  byte_reg, byte_next;
  logic [1:0]  nbyte_reg, nbyte_next;
  logic        rdm_reg, rdm_next;
  logic        samp_reg, samp_next;
  logic [23:0] sh_reg, sh_next;
  logic [3:0]  div_reg, div_next;
  logic        sync_reg, sync_next;
  logic        w3b_reg, w3b_next;
  ibe_line_t   ovr_reg, ovr_next;
  logic        done_reg, done_next;
  ibe_line_t   oe_reg, oe_next;
  ibe_line_t   zero_reg;
  logic [1:0]  sts_reg, sts_next;
  logic [1:0]  msk_reg, msk_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        irq_reg, irq_next;
  logic        ev_done, ev_nack;
  logic        tick, stall, rx, rx_ahead, last, ctrl_wr, launch;
  ibe_line_t   drv;

  // Line levels the engine wants for a state and quarter phase
  function automatic ibe_line_t line_drive(ibe_state_t st, logic [1:0] q, logic dbit);
    ibe_line_t l;
    l = '{scl: 1'b1, sda: 1'b1};
    case (st)
      ST_START: begin
        l.scl = (q < 2'h2);
        l.sda = (q == 2'h0);
      end
      ST_BIT: begin
        l.scl = (q == 2'h1) || (q == 2'h2);
        l.sda = dbit;
      end
      ST_ACK: begin
        l.scl = (q == 2'h1) || (q == 2'h2);
      end
      ST_STOP: begin
        l.scl = (q != 2'h0);
        l.sda = (q >= 2'h2);
      end
      default: l = '{scl: 1'b1, sda: 1'b1};
    endcase
    return l;
  endfunction

  // Quarter-bit ticks at clock / 16 / divider per bit
  ibe_rate_div #(
    .DIV_W (4)
  ) u_rate (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .run     (state_reg != ST_IDLE),
    .div     (div_reg),
    .tick    (tick)
  );

  // Decode and sequencing terms
  assign ctrl_wr = wr && (addr == `IBE_CTRL_OFS);
  assign launch  = ctrl_wr && (state_reg == ST_IDLE) && (wdata[7:`IBE_DIV_LSB] != 4'h0);
  assign rx      = rdm_reg && (byte_reg == 2'h1);
  assign last    = (byte_reg == nbyte_reg - 2'h1);
  // Released clock held low by the slave freezes the phase
  assign stall   = sync_reg && (q_reg == 2'h1) && !line_i.scl &&
                   (state_reg == ST_BIT || state_reg == ST_ACK || state_reg == ST_STOP);

  // Next values of control word and engine
  always_comb begin
    st_next    = state_reg;
    q_next     = q_reg;
    bit_next   = bit_reg;
    byte_next  = byte_reg;
    nbyte_next = nbyte_reg;
    rdm_next   = rdm_reg;
    samp_next  = samp_reg;
    sh_next    = sh_reg;
    div_next   = div_reg;
    sync_next  = sync_reg;
    w3b_next   = w3b_reg;
    ovr_next   = ovr_reg;
    done_next  = done_reg;
    ev_done    = 1'b0;
    ev_nack    = 1'b0;
    if (ctrl_wr) begin
      ovr_next = '{scl: wdata[`IBE_SCL_BIT], sda: wdata[`IBE_SDA_BIT]};
      if (state_reg == ST_IDLE) begin
        sh_next   = wdata[31:`IBE_BYTES_LSB];
        div_next  = wdata[7:`IBE_DIV_LSB];
        sync_next = wdata[`IBE_SYNC_BIT];
        w3b_next  = wdata[`IBE_W3B_BIT];
      end
      if (launch) begin
        st_next    = ST_START;
        q_next     = 2'h0;
        bit_next   = 3'h0;
        byte_next  = 2'h0;
        rdm_next   = wdata[`IBE_DIR_BIT];
        nbyte_next = (wdata[`IBE_DIR_BIT] || !wdata[`IBE_W3B_BIT]) ? 2'h2 : 2'h3;
        done_next  = 1'b0;
      end
    end
    // A control write while busy must not swallow a quarter tick
    if (tick && !stall && state_reg != ST_IDLE) begin
      q_next = q_reg + 2'h1;
      case (state_reg)
        ST_START: begin
          if (q_reg == 2'h3) begin
            st_next = ST_BIT;
          end
        end
        ST_BIT: begin
          if (q_reg == 2'h2) begin
            samp_next = line_i.sda;
          end
          if (q_reg == 2'h3) begin
            if (rx) begin
              sh_next[7:0] = {sh_reg[6:0], samp_reg};
            end else begin
              sh_next = {sh_reg[22:0], 1'b0};
            end
            bit_next = bit_reg + 3'h1;
            if (bit_reg == 3'h7) begin
              st_next = ST_ACK;
            end
          end
        end
        ST_ACK: begin
          if (q_reg == 2'h2 && !rx && line_i.sda) begin
            ev_nack = 1'b1;
          end
          if (q_reg == 2'h3) begin
            if (last) begin
              st_next = ST_STOP;
            end else begin
              st_next   = ST_BIT;
              byte_next = byte_reg + 2'h1;
            end
          end
        end
        ST_STOP: begin
          if (q_reg == 2'h3) begin
            st_next   = ST_IDLE;
            done_next = 1'b1;
            ev_done   = 1'b1;
          end
        end
        default: st_next = ST_IDLE;
      endcase
    end
    // Received byte and ack are released; overrides pull low in any mode
    rx_ahead = rdm_next && (byte_next == 2'h1);
    drv      = line_drive(st_next, q_next, rx_ahead | sh_next[23]);
    oe_next  = '{scl: ~(drv.scl & ovr_next.scl), sda: ~(drv.sda & ovr_next.sda)};
  end

  // Control word and engine registers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      q_reg     <= 2'h0;
      bit_reg   <= 3'h0;
      byte_reg  <= 2'h0;
      nbyte_reg <= 2'h2;
      rdm_reg   <= 1'b0;
      samp_reg  <= 1'b1;
      sh_reg    <= `IBE_BYTES_RST;
      div_reg   <= `IBE_DIV_RST;
      sync_reg  <= 1'b0;
      w3b_reg   <= 1'b0;
      ovr_reg   <= '{scl: 1'b1, sda: 1'b1};
      done_reg  <= 1'b0;
      oe_reg    <= '{scl: 1'b0, sda: 1'b0};
      zero_reg  <= '{scl: 1'b0, sda: 1'b0};
    end else begin
      state_reg <= st_next;
      q_reg     <= q_next;
      bit_reg   <= bit_next;
      byte_reg  <= byte_next;
      nbyte_reg <= nbyte_next;
      rdm_reg   <= rdm_next;
      samp_reg  <= samp_next;
      sh_reg    <= sh_next;
      div_reg   <= div_next;
      sync_reg  <= sync_next;
      w3b_reg   <= w3b_next;
      ovr_reg   <= ovr_next;
      done_reg  <= done_next;
      oe_reg    <= oe_next;
      zero_reg  <= '{scl: 1'b0, sda: 1'b0};
    end
  end

  // Status, mask, read data and interrupt; a new event wins over its clear
  always_comb begin
    sts_next = sts_reg;
    msk_next = msk_reg;
    if (wr && addr == `IBE_STS_OFS) begin
      sts_next = sts_reg & ~wdata[1:0];
    end
    if (wr && addr == `IBE_MSK_OFS) begin
      msk_next = wdata[1:0];
    end
    sts_next[`IBE_EV_DONE] = sts_next[`IBE_EV_DONE] | ev_done;
    sts_next[`IBE_EV_NACK] = sts_next[`IBE_EV_NACK] | ev_nack;
    irq_next   = |(sts_next & msk_next);
    rdata_next = 32'h00000000;
    if (rd) begin
      case (addr)
        `IBE_CTRL_OFS: rdata_next = {sh_reg, div_reg, sync_reg, w3b_reg,
                                     line_i.scl, line_i.sda};
        `IBE_STS_OFS: begin
          rdata_next[1:0]          = sts_reg;
          rdata_next[`IBE_ST_DONE] = done_reg;
          rdata_next[`IBE_ST_BUSY] = (state_reg != ST_IDLE);
        end
        `IBE_MSK_OFS: rdata_next[1:0] = msk_reg;
        default:      rdata_next = 32'h00000000;
      endcase
    end
  end

  // Bus-side registers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sts_reg   <= 2'h0;
      msk_reg   <= `IBE_MSK_RST;
      rdata_reg <= 32'h00000000;
      irq_reg   <= 1'b0;
    end else begin
      sts_reg   <= sts_next;
      msk_reg   <= msk_next;
      rdata_reg <= rdata_next;
      irq_reg   <= irq_next;
    end
  end

  assign rdata   = rdata_reg;
  assign line_o  = zero_reg;
  assign line_oe = oe_reg;
  assign irq     = irq_reg;

  // Checks
  a_first_bit_out: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    state_reg == ST_START && q_reg == 2'h3 && tick && ovr_reg.sda && !ctrl_wr
    |=> oe_reg.sda == ~$past(sh_reg[23]))
    else $error("first data bit not taken from top control byte");

  a_rx_shift_in: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    state_reg == ST_BIT && rx && q_reg == 2'h3 && tick && !stall && !ctrl_wr
    |=> sh_reg[0] == $past(samp_reg) && sh_reg[7:1] == $past(sh_reg[6:0]))
    else $error("received bit not shifted into low byte");

  a_tick_spacing: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    tick |=> !tick [*3])
    else $error("quarter ticks closer than four cycles");

  a_stretch_holds: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    stall && !ctrl_wr |=> q_reg == 2'h1 && state_reg == $past(state_reg))
    else $error("phase advanced while slave held clock");

  a_no_stretch: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    !sync_reg && tick && q_reg == 2'h1 && state_reg != ST_IDLE && !ctrl_wr
    |=> q_reg == 2'h2)
    else $error("phase stalled with stretching disabled");

  a_write_len: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    launch && !wdata[`IBE_DIR_BIT]
    |=> nbyte_reg == ($past(wdata[`IBE_W3B_BIT]) ? 2'h3 : 2'h2))
    else $error("write length does not follow select bit");

  a_scl_override: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    ctrl_wr && !wdata[`IBE_SCL_BIT] |=> oe_reg.scl && !ovr_reg.scl)
    else $error("clock override did not pull line low");

  a_sda_override: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    ctrl_wr && !wdata[`IBE_SDA_BIT] |=> oe_reg.sda && !ovr_reg.sda)
    else $error("data override did not pull line low");

  a_pin_readback: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    rd && addr == `IBE_CTRL_OFS
    |=> rdata_reg[1:0] == {$past(line_i.scl), $past(line_i.sda)})
    else $error("override bits do not read pin levels");

  a_sw_readback: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    ctrl_wr && state_reg == ST_IDLE && wdata[7:`IBE_DIV_LSB] == 4'h0
    |=> sh_reg == $past(wdata[31:`IBE_BYTES_LSB]) && state_reg == ST_IDLE)
    else $error("software mode byte fields not held as written");

  a_rx_stable: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    done_reg && rdm_reg && state_reg == ST_IDLE && !ctrl_wr |=> $stable(sh_reg[7:0]))
    else $error("received byte changed after done");

  a_done_clear: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    launch |=> !done_reg && state_reg == ST_START)
    else $error("launch did not start engine and clear done");

  a_done_set: assert property (
    @(posedge clk_sys) disable iff (!arst_n)
    state_reg == ST_STOP && q_reg == 2'h3 && tick && !stall && !ctrl_wr
    |=> done_reg && state_reg == ST_IDLE && sts_reg[`IBE_EV_DONE])
    else $error("stop end did not set done");
endmodule

// file: verif/ibe_slave_model.sv
// Behavioural two-wire slave: acks every byte, answers a read with one byte.
// Assumes pull-up resolved lines; the bench gives the read byte and stretch request.
`timescale 1ns/1ps
module ibe_slave_model (
  input  wire logic       scl,     // Resolved clock line
  input  wire logic       sda,     // Resolved data line
  input  wire logic [7:0] rd_byte, // Byte returned on a read
  input  wire logic       stretch, // Hold the clock low after each fall
  output logic            scl_oe,  // High while pulling the clock low
  output logic            sda_oe   // High while pulling the data low
);
  logic [7:0] rx_q[$]; // Bytes received in the current transaction
  logic [7:0] sh;
  logic       dir;
  logic       b;
  logic       stp;
  int         nbyte;

  // One bit, sampled on the rising clock; data rising while clock high is a stop
  task automatic get_bit(output logic bit_v, output logic stop_v);
    @(posedge scl);
    bit_v = sda;
    @(negedge scl or posedge sda);
    stop_v = scl;
  endtask

  // Transaction walker: receive bytes and ack, or send the read byte
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    forever begin
      @(negedge sda iff scl === 1'b1);
      nbyte = 0;
      stp = 1'b0;
      while (!stp) begin
        if (nbyte == 1 && dir) begin
          for (int i = 7; i >= 0; i--) begin
            sda_oe = ~rd_byte[i];
            @(negedge scl);
          end
          sda_oe = 1'b0; // Release for the master's closing bit
          nbyte++;
        end else begin
          for (int i = 7; i >= 0 && !stp; i--) begin
            get_bit(b, stp);
            sh[i] = b;
          end
          if (!stp) begin
            rx_q.push_back(sh);
            if (nbyte == 0) dir = sh[0];
            sda_oe = 1'b1; // Ack
            @(negedge scl);
            sda_oe = 1'b0;
            nbyte++;
          end
        end
      end
    end
  end

  // Wait states: hold the clock low a long while after each fall
  always @(negedge scl) begin
    if (stretch) begin
      scl_oe = 1'b1;
      #1000 scl_oe = 1'b0;
    end
  end
endmodule

// file: verif/tb_i2c_master_byte_engine.sv
// Bench for the serial byte engine: register tasks, slave model, random traffic.
// Assumes the package, defines and slave model are compiled first.
`timescale 1ns/1ps
`include "ibe_defines.svh"
module tb_i2c_master_byte_engine import ibe_pkg::*;;
  logic                   clk_sys     = 1'b0;
  logic                   arst_n      = 1'b0;
  logic [`IBE_ADDR_W-1:0] addr        = '0;
  logic [31:0]            wdata       = 32'h0;
  logic                   wr          = 1'b0;
  logic                   rd          = 1'b0;
  logic [31:0]            rdata;
  ibe_line_t              line_i;
  ibe_line_t              line_o;
  ibe_line_t              line_oe;
  logic                   irq;
  logic                   slv_scl_oe;
  logic                   slv_sda_oe;
  logic                   slv_stretch = 1'b0;
  logic                   tb_pull_scl = 1'b0;
  logic                   slv_mute    = 1'b0;
  logic [7:0]             slv_rd_byte = 8'h00;
  logic [31:0]            r;
  logic [31:0]            w;
  int                     seed        = 40;
  int                     fail_count  = 0;
  int                     cmp_count   = 0;
  int                     cyc         = 0;
  int                     dur;

  // Clock and cycle count
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;

  // Open-drain lines with pull-ups
  assign line_i.scl = ~(line_oe.scl | slv_scl_oe | tb_pull_scl);
  assign line_i.sda = ~(line_oe.sda | (slv_sda_oe & ~slv_mute));

  ibe_byte_engine dut (.clk_sys(clk_sys), .arst_n(arst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .line_i(line_i), .line_o(line_o),
    .line_oe(line_oe), .irq(irq));

  ibe_slave_model slv (.scl(line_i.scl), .sda(line_i.sda), .rd_byte(slv_rd_byte),
    .stretch(slv_stretch), .scl_oe(slv_scl_oe), .sda_oe(slv_sda_oe));

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Cycles from launch to stop end: start, nw bytes of 9 bits, stop
  function automatic int exp_cycles(int dv, int nw);
    return 16 * dv * (2 + 9 * nw);
  endfunction

  task automatic wreg(input logic [`IBE_ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr    <= 1'b0;
  endtask

  task automatic rreg(input logic [`IBE_ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd   <= 1'b0;
    @(negedge clk_sys);
    d = rdata;
  endtask

  task automatic wait_done();
    logic [31:0] s;
    int          n;
    n = 0;
    s = '0;
    while (s[`IBE_ST_DONE] !== 1'b1 && n < 10000) begin
      rreg(`IBE_STS_OFS, s);
      n++;
    end
    if (n >= 10000) begin
      fail_count++;
      conclude();
    end
  endtask

  // Launch one transaction, try a refused relaunch, then check what the slave saw
  task automatic hw_run(input logic [3:0] dv, input logic w3b, input logic rdir,
                        input logic sync, output int t);
    logic [31:0] c;
    logic [31:0] s;
    int          nw;
    int          t0;
    int          e;
    c = $random(seed);
    c[24] = rdir;
    c[7:0] = {dv, sync, w3b, 2'b11};
    nw = rdir ? 2 : (w3b ? 3 : 2);
    e = exp_cycles(dv, nw);
    slv.rx_q.delete();
    slv_rd_byte <= 8'($random(seed));
    wreg(`IBE_CTRL_OFS, c);
    t0 = cyc;
    wreg(`IBE_CTRL_OFS, {~c[31:8], 8'h13}); // Ignored while busy
    rreg(`IBE_STS_OFS, s);
    check("busy_launch", s[9:8], 2'b10);
    wait_done();
    t = cyc - t0;
    if (!(slv_stretch && !sync)) begin
      check("rx_count", slv.rx_q.size(), rdir ? 1 : nw);
      for (int k = 0; k < slv.rx_q.size(); k++)
        check("wire_byte", slv.rx_q[k], c[31-8*k -: 8]);
    end
    if (rdir) begin
      rreg(`IBE_CTRL_OFS, s);
      check("rx_byte", s[15:8], slv_rd_byte);
    end
    if (!sync) check("duration", 32'((t >= e - 4) && (t <= e + 12)), 32'h1);
  endtask

  // Watchdog
  initial begin
    #300000;
    fail_count++;
    conclude();
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    rreg(`IBE_CTRL_OFS, r);
    check("ctrl_rst", r, 32'h0000_0003);
    rreg(`IBE_STS_OFS, r);
    check("sts_rst", r, 32'h0);
    rreg(12'h104, r);
    check("unmapped", r, 32'h0);
    check("oe_rst", {30'h0, line_oe}, 32'h0);
    check("line_o", {30'h0, line_o}, 32'h0);
    // Software mode: lines follow overrides, fields read back as written
    wreg(`IBE_CTRL_OFS, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      w = $random(seed);
      w[7:4] = 4'h0;
      w[1] = 1'b0;
      wreg(`IBE_CTRL_OFS, w);
      repeat (2) @(negedge clk_sys);
      check("oe_sw", {30'h0, line_oe}, {30'h0, 1'b1, ~w[0]});
      rreg(`IBE_CTRL_OFS, r);
      check("ctrl_sw", r, {w[31:2], 1'b0, w[0]});
    end
    wreg(`IBE_CTRL_OFS, 32'h0000_0003);
    tb_pull_scl <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rreg(`IBE_CTRL_OFS, r);
    check("scl_pin", r[1:0], 2'b01);
    check("scl_oe", line_oe.scl, 1'b0);
    tb_pull_scl <= 1'b0;
    // Hardware mode, interrupt held off by mask, raised when unmasked, cleared
    hw_run(4'h1, 1'b0, 1'b0, 1'b0, dur);
    check("irq_off", irq, 1'b0);
    wreg(`IBE_MSK_OFS, 32'h1);
    repeat (2) @(negedge clk_sys);
    check("irq_on", irq, 1'b1);
    wreg(`IBE_STS_OFS, 32'h1);
    repeat (2) @(negedge clk_sys);
    check("irq_clr", irq, 1'b0);
    rreg(`IBE_STS_OFS, r);
    check("sts_after", r, 32'h100);
    hw_run(4'hF, 1'b1, 1'b0, 1'b0, dur);
    hw_run(4'h2, 1'b0, 1'b1, 1'b0, dur);
    for (int i = 0; i < 6; i++) begin
      w = $random(seed);
      hw_run(4'h1 + {3'h0, w[0]}, w[1], w[2], 1'b0, dur);
    end
    // Slave acks hidden: every written byte is refused, nack event set and cleared
    slv_mute <= 1'b1;
    hw_run(4'h1, 1'b0, 1'b0, 1'b0, dur);
    slv_mute <= 1'b0;
    rreg(`IBE_STS_OFS, r);
    check("nack_set", r[1], 1'b1);
    wreg(`IBE_STS_OFS, 32'h2);
    rreg(`IBE_STS_OFS, r);
    check("nack_clr", r[1], 1'b0);
    // Slave wait states honoured only with the wait enable set
    slv_stretch <= 1'b1;
    hw_run(4'h2, 1'b0, 1'b0, 1'b1, dur);
    check("stretched", 32'(dur > exp_cycles(2, 2) + 1000), 32'h1);
    hw_run(4'h2, 1'b0, 1'b0, 1'b0, dur);
    conclude();
  end
endmodule
